// ==== rtl/sns_regs.svh ====
// Purpose: Register offsets, field positions and reset values of the sensor bank.
// Assumes: Pointer values are byte codes seen on the serial bus.
// Notes:   Definitions only; included by its bare name.
`ifndef SNS_REGS_SVH
`define SNS_REGS_SVH

`define SNS_PTR_RESET     8'h00
`define SNS_PTR_LT_HI     8'h00
`define SNS_PTR_RT_HI     8'h01
`define SNS_PTR_STATUS    8'h02
`define SNS_PTR_CFG_RD    8'h03
`define SNS_PTR_CFG_WR    8'h09
`define SNS_PTR_RT_LO     8'h10
`define SNS_PTR_LT_LO     8'h15
`define SNS_UNMAPPED_DATA 8'h00

`define SNS_CFG_RESET     8'h00
`define SNS_CFG_WMASK     8'hE4
`define SNS_CFG_MASK_BIT  7
`define SNS_CFG_SD_BIT    6
`define SNS_CFG_MODE_BIT  5
`define SNS_CFG_RANGE_BIT 2

`define SNS_RES_RESET     12'h000
`define SNS_STICKY_ALARM  5'h1F
`define SNS_STICKY_SECOND 5'h01

`endif

// ==== rtl/sns_pkg.sv ====
// Purpose: Shared types of the sensor register bank.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Offsets and values live in sns_regs.svh.
package sns_pkg;
  typedef enum logic {SNS_MODE_ALARM, SNS_MODE_SECOND} sns_pin_mode_t;
  typedef logic [7:0] sns_byte_t;
endpackage

// ==== rtl/sns_flag_if.sv ====
// Purpose: Carries trip conditions in and flags and pin levels out of the flag unit.
// Assumes: Single clock domain, sys_clk.
// Notes:   trip order is local high, local low, remote high, remote low, open.
`timescale 1ns/1ps
interface sns_flag_if;
  logic [4:0]                 trip;
  logic [1:0]                 crit_over;
  logic [1:0]                 crit_clear;
  sns_pkg::sns_pin_mode_t     mode;
  logic                       mask;
  logic                       status_rd;
  logic                       ara_rd;
  logic [6:0]                 flags;
  logic                       pin6_n;
  logic                       otemp_n;

  modport top   (output trip, crit_over, crit_clear, mode, mask, status_rd, ara_rd,
                 input flags, pin6_n, otemp_n);
  modport unit  (input trip, crit_over, crit_clear, mode, mask, status_rd, ara_rd,
                 output flags, pin6_n, otemp_n);
endinterface

// ==== rtl/sns_result_lock.sv ====
// Purpose: One channel's split result with cross-byte read freeze.
// Assumes: Reads are one-cycle pulses on sys_clk.
// Notes:   Each byte is kept apart so one can be frozen while the other updates.
`timescale 1ns/1ps
`include "sns_regs.svh"
module sns_result_lock (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        upd,
  input  wire logic [11:0] res,
  input  wire logic        rd_hi,
  input  wire logic        rd_lo,
  input  wire logic        rd_other,
  output logic      [7:0]  hi_byte,
  output logic      [7:0]  lo_byte
);
  logic [7:0] hi_q;
  logic [3:0] lo_q;
  logic       lock_hi_q;
  logic       lock_lo_q;

  wire lock_lo_d = rd_hi ? ~lock_hi_q : (rd_lo | rd_other) ? 1'b0 : lock_lo_q;
  wire lock_hi_d = rd_lo ? ~lock_lo_q : (rd_hi | rd_other) ? 1'b0 : lock_hi_q;

  // converter rewrites unlocked bytes; zero at reset.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {hi_q, lo_q} <= `SNS_RES_RESET;
      lock_hi_q <= 1'b0;
      lock_lo_q <= 1'b0;
    end else begin
      if (upd && !lock_hi_q) hi_q <= res[11:4];
      if (upd && !lock_lo_q) lo_q <= res[3:0];
      lock_hi_q <= lock_hi_d;
      lock_lo_q <= lock_lo_d;
    end
  end

  // fraction sits in the upper nibble of the low byte.
  assign hi_byte = hi_q;
  assign lo_byte = {lo_q, 4'h0};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_lock_hold: assert property (lock_lo_q && upd |=> lo_q == $past(lo_q))
    else $error("Frozen low byte changed.");
  chk_free_update: assert property (upd && !lock_hi_q |=> hi_q == $past(res[11:4]))
    else $error("Unfrozen high byte missed an update.");
endmodule

// ==== rtl/sns_flag_unit.sv ====
// Purpose: Status flags, alarm latch and the two over-temperature pins.
// Assumes: Trip conditions are steady between conversions.
// Notes:   Hardware set always wins over a read clear.
`timescale 1ns/1ps
`include "sns_regs.svh"
module sns_flag_unit (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  sns_flag_if.unit  fi
);
  logic [4:0] lim_q;
  logic [1:0] crit_q;
  logic       latch_q;
  logic       pin6_n_q;
  logic       otemp_n_q;

  wire alarm = (fi.mode == sns_pkg::SNS_MODE_ALARM);
  // which flags are sticky depends on pin function.
  wire [4:0] sticky = alarm ? `SNS_STICKY_ALARM : `SNS_STICKY_SECOND;
  wire [4:0] lim_d;
  wire [1:0] crit_d;

  // read clears only once the cause is gone.
  genvar i;
  for (i = 0; i < 5; i++) begin : g_lim
    assign lim_d[i] = fi.trip[i] | (sticky[i] & lim_q[i] & ~fi.status_rd);
  end
  for (i = 0; i < 2; i++) begin : g_crit
    assign crit_d[i] = fi.crit_over[i] | (crit_q[i] & ~fi.crit_clear[i]);
  end

  // latch drops on address read only when quiet.
  wire quiet   = ~|lim_q & ~|fi.trip;
  wire latch_d = (alarm & |lim_q) | (latch_q & ~(fi.ara_rd & quiet));
  // alarm drive, masked only in alarm mode; second output.
  wire pin6_d  = alarm ? ~(latch_d & ~fi.mask) : ~(lim_d[4] | lim_d[2]);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lim_q     <= 5'h00;
      crit_q    <= 2'h0;
      latch_q   <= 1'b0;
      pin6_n_q  <= 1'b1;
      otemp_n_q <= 1'b1;
    end else begin
      lim_q     <= lim_d;
      crit_q    <= crit_d;
      latch_q   <= latch_d;
      pin6_n_q  <= pin6_d;
      otemp_n_q <= ~|crit_d;
    end
  end

  // bit order local high, local low, remote high, remote low, open, criticals.
  assign fi.flags   = {lim_q, crit_q};
  assign fi.otemp_n = otemp_n_q;
  assign fi.pin6_n  = pin6_n_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_flag_sticky: assert property (alarm && lim_q[4] && !fi.status_rd |=> lim_q[4])
    else $error("Sticky limit flag dropped without a read.");
  chk_latch_status: assert property (latch_q && !fi.ara_rd |=> latch_q)
    else $error("Alarm latch cleared without address read.");
  chk_crit_set: assert property (fi.crit_over[1] |=> crit_q[1])
    else $error("Critical flag missed an over-limit.");
  chk_over_temp_out_n_pin: assert property (|fi.crit_over |=> !fi.otemp_n)
    else $error("Over-temp pin high while a critical flag is set.");
  chk_alarm_pin: assert property (alarm && lim_q[0] && !fi.mask |=> !fi.pin6_n)
    else $error("Alarm pin not low after open flag.");
endmodule

// ==== rtl/sns_reg_bank.sv ====
// Purpose: Register side of a two-channel temperature monitor.
// Assumes: A two-wire protocol engine on sys_clk hands over byte commands.
// Notes:   Limit values arrive from the limit bank; the converter is outside.
//
// Summary of operation
// - Eight-bit pointer reloaded by every write.
// - Pointer is zero after reset.
// - Local result split at 00h and 15h.
// - Remote result split at 01h and 10h.
// - Low byte upper nibble holds sixteenths of degree.
// - Results read-only, rewritten per conversion.
// - Reading one byte freezes the other.
// - Result registers zero after reset.
// - Status bit 7 shows conversion busy.
// - Status bits 6..0 are the event flags.
// - Alarm mode: five sticky flags; else open.
// - In alarm mode any sticky flag sets alarm latch, pin low.
// - Status read clears sticky flags once cause gone.
// - Latch clears on address read when quiet.
// - Critical flags clear at or below limit minus hysteresis.
// - Over-temp pin low while a critical flag is set.
// - Second-output mode follows high limits only.
// - Setup written at 09h, read 03h, reset zero.
// - Setup bits: mask, shutdown, pin mode.
// - Setup bit 2 selects extended range.
// - Mask acts only in alarm mode.
// - Shutdown stops after the current sequence.
`timescale 1ns/1ps
`include "sns_regs.svh"
module sns_reg_bank (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       bus_ptr_wr,
  input  wire logic       bus_data_wr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_rd,
  input  wire logic       bus_ara_rd,
  output logic      [7:0] bus_rdata,
  output logic            bus_rvalid,
  input  wire logic       conv_done,
  input  wire logic       conv_busy,
  input  wire logic [11:0] conv_local,
  input  wire logic [11:0] conv_remote,
  input  wire logic       conv_open,
  input  wire logic [7:0] lim_local_high,
  input  wire logic [7:0] lim_local_low,
  input  wire logic [7:0] lim_remote_high,
  input  wire logic [7:0] lim_remote_low,
  input  wire logic [7:0] lim_local_crit,
  input  wire logic [7:0] lim_remote_crit,
  input  wire logic [7:0] lim_hyst,
  output logic            shutdown_req,
  output logic            range_ext,
  output logic            alert_pin_n,
  output logic            over_temp_out_n
);
  sns_pkg::sns_byte_t register_selector_q;
  sns_pkg::sns_byte_t device_setup_q;
  sns_pkg::sns_byte_t rdata_q;
  logic               rvalid_q;
  logic [7:0]         last_local_q;
  logic [7:0]         last_remote_q;
  logic               open_q;
  logic [7:0]         lt_hi;
  logic [7:0]         lt_lo;
  logic [7:0]         rt_hi;
  logic [7:0]         rt_lo;

  sns_flag_if fi ();

  // Pointer decode for reads and the setup write; each term names one visible register.
  wire sel_lt_hi  = (register_selector_q == `SNS_PTR_LT_HI);
  wire sel_rt_hi  = (register_selector_q == `SNS_PTR_RT_HI);
  wire sel_status = (register_selector_q == `SNS_PTR_STATUS);
  wire sel_cfg_rd = (register_selector_q == `SNS_PTR_CFG_RD);
  wire sel_cfg_wr = (register_selector_q == `SNS_PTR_CFG_WR);
  wire sel_rt_lo  = (register_selector_q == `SNS_PTR_RT_LO);
  wire sel_lt_lo  = (register_selector_q == `SNS_PTR_LT_LO);
  // One term for any mapped pointer; everything else reads as zero.
  wire sel_any    = sel_lt_hi | sel_rt_hi | sel_status | sel_cfg_rd | sel_rt_lo | sel_lt_lo;

  // A read of anything other than a channel's two bytes ends that channel's freeze.
  wire rd_lt_hi = bus_rd & sel_lt_hi;
  wire rd_lt_lo = bus_rd & sel_lt_lo;
  wire rd_rt_hi = bus_rd & sel_rt_hi;
  wire rd_rt_lo = bus_rd & sel_rt_lo;
  wire rd_l_other = bus_rd & ~sel_lt_hi & ~sel_lt_lo;
  wire rd_r_other = bus_rd & ~sel_rt_hi & ~sel_rt_lo;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      register_selector_q <= `SNS_PTR_RESET;
    end else if (bus_ptr_wr) begin
      register_selector_q <= bus_wdata;
    end
  end

  // setup write; reserved bits are forced to zero on the way in.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      device_setup_q <= `SNS_CFG_RESET;
    end else if (bus_data_wr && sel_cfg_wr) begin
      device_setup_q <= bus_wdata & `SNS_CFG_WMASK;
    end
  end

  // converter sees a level and finishes its sequence before stopping.
  assign shutdown_req = device_setup_q[`SNS_CFG_SD_BIT];
  // range select handed to the converter.
  assign range_ext    = device_setup_q[`SNS_CFG_RANGE_BIT];

  // Latest, unfrozen high bytes feed the comparators so a pending host read
  // never delays limit detection.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_local_q  <= 8'h00;
      last_remote_q <= 8'h00;
      open_q        <= 1'b0;
    end else if (conv_done) begin
      last_local_q  <= conv_local[11:4];
      last_remote_q <= conv_remote[11:4];
      open_q        <= conv_open;
    end
  end

  // one lock unit per channel, local first.
  genvar ch;
  for (ch = 0; ch < 2; ch++) begin : g_chan
    logic [11:0] res;
    logic        rd_hi;
    logic        rd_lo;
    logic        rd_other;
    logic [7:0]  hi_byte;
    logic [7:0]  lo_byte;
    assign res      = (ch == 0) ? conv_local : conv_remote;
    assign rd_hi    = (ch == 0) ? rd_lt_hi : rd_rt_hi;
    assign rd_lo    = (ch == 0) ? rd_lt_lo : rd_rt_lo;
    assign rd_other = (ch == 0) ? rd_l_other : rd_r_other;
    sns_result_lock u_lock (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .upd      (conv_done),
      .res      (res),
      .rd_hi    (rd_hi),
      .rd_lo    (rd_lo),
      .rd_other (rd_other),
      .hi_byte  (hi_byte),
      .lo_byte  (lo_byte)
    );
  end
  assign lt_hi = g_chan[0].hi_byte;
  assign lt_lo = g_chan[0].lo_byte;
  assign rt_hi = g_chan[1].hi_byte;
  assign rt_lo = g_chan[1].lo_byte;

  // Limit comparators on whole degrees; both formats compare as unsigned.
  wire lh_trip = last_local_q  > lim_local_high;
  wire ll_trip = last_local_q  < lim_local_low;
  wire rh_trip = last_remote_q > lim_remote_high;
  wire rl_trip = last_remote_q < lim_remote_low;

  // release point is limit minus hysteresis; adding avoids underflow.
  wire [8:0] l_rel = {1'b0, last_local_q}  + {1'b0, lim_hyst};
  wire [8:0] r_rel = {1'b0, last_remote_q} + {1'b0, lim_hyst};
  wire l_crit_over  = last_local_q  > lim_local_crit;
  wire r_crit_over  = last_remote_q > lim_remote_crit;
  wire l_crit_clear = l_rel <= {1'b0, lim_local_crit};
  wire r_crit_clear = r_rel <= {1'b0, lim_remote_crit};

  // Flag unit hookup.
  assign fi.trip       = {lh_trip, ll_trip, rh_trip, rl_trip, open_q};
  assign fi.crit_over  = {r_crit_over, l_crit_over};
  assign fi.crit_clear = {r_crit_clear, l_crit_clear};
  assign fi.mode       = device_setup_q[`SNS_CFG_MODE_BIT] ? sns_pkg::SNS_MODE_SECOND
                                                           : sns_pkg::SNS_MODE_ALARM;
  assign fi.mask       = device_setup_q[`SNS_CFG_MASK_BIT];
  // status read pulse drives the conditional clear.
  assign fi.status_rd  = bus_rd & sel_status;
  // only the alert-address read may release the latch.
  assign fi.ara_rd     = bus_ara_rd;

  sns_flag_unit u_flags (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .fi      (fi.unit)
  );

  assign alert_pin_n     = fi.pin6_n;
  assign over_temp_out_n = fi.otemp_n;

  // status byte shows busy and the flags before any clear.
  wire [7:0] status_byte = {conv_busy, fi.flags};

  // Read mux; unmapped pointers answer zero since other banks sit elsewhere.
  wire [7:0] rd_mux = sel_lt_hi  ? lt_hi :
                      sel_rt_hi  ? rt_hi :
                      sel_status ? status_byte :
                      sel_cfg_rd ? device_setup_q :
                      sel_rt_lo  ? rt_lo :
                      sel_lt_lo  ? lt_lo : `SNS_UNMAPPED_DATA;

  // Read data are registered: answer one edge after the read pulse.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= bus_rd;
      if (bus_rd) rdata_q <= rd_mux;
    end
  end

  assign bus_rdata  = rdata_q;
  assign bus_rvalid = rvalid_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_ptr_reload: assert property (bus_ptr_wr |=> register_selector_q == $past(bus_wdata))
    else $error("Pointer not reloaded by write.");
  chk_ptr_hold: assert property (!bus_ptr_wr |=> $stable(register_selector_q))
    else $error("Pointer changed without a write.");
  chk_cfg_write: assert property (bus_data_wr && sel_cfg_wr
      |=> device_setup_q == ($past(bus_wdata) & 8'hE4))
    else $error("Setup write not stored.");
  chk_cfg_read: assert property (bus_rd && sel_cfg_rd
      |=> bus_rvalid && bus_rdata == $past(device_setup_q))
    else $error("Setup read returned wrong value.");
  chk_status_busy: assert property (bus_rd && sel_status
      |=> bus_rdata[7] == $past(conv_busy))
    else $error("Busy bit wrong in status.");
  chk_lt_readback: assert property (bus_rd && sel_lt_hi |=> bus_rdata == $past(lt_hi))
    else $error("Local high byte readback wrong.");
  chk_mask_second: assert property (fi.mode == sns_pkg::SNS_MODE_SECOND && lh_trip
      |=> !alert_pin_n)
    else $error("Second output missed a high-limit trip.");

  // Every read is answered one edge later, and nothing else raises the strobe.
  chk_rvalid_rise: assert property (bus_rd |=> bus_rvalid)
    else $error("Read got no answer.");
  chk_rvalid_idle: assert property (!bus_rd |=> !bus_rvalid)
    else $error("Answer without a read.");

  // Pointers outside the map read as zero so a stray read is harmless.
  chk_unmapped_zero: assert property (bus_rd && !sel_any |=> bus_rdata == 8'h00)
    else $error("Unmapped pointer returned data.");

  // Setup changes only through its write pointer; reserved bits never stick.
  chk_cfg_hold: assert property (!(bus_data_wr && sel_cfg_wr)
      |=> $stable(device_setup_q))
    else $error("Setup changed without a write.");
  chk_cfg_reserved: assert property (device_setup_q[4:3] == 2'h0
      && device_setup_q[1:0] == 2'h0)
    else $error("Reserved setup bit set.");

  // The converter controls follow the written byte on the next edge.
  chk_sd_write: assert property (bus_data_wr && sel_cfg_wr
      |=> shutdown_req == $past(bus_wdata[6]))
    else $error("Shutdown request missed a setup write.");
  chk_range_write: assert property (bus_data_wr && sel_cfg_wr
      |=> range_ext == $past(bus_wdata[2]))
    else $error("Range select missed a setup write.");

  // Results move only on a conversion; the bus can never write them.
  chk_result_ro: assert property (!conv_done |=> $stable(lt_hi) && $stable(rt_hi))
    else $error("Result byte changed without a conversion.");

  // Remote high byte readback and the zero-filled low nibble.
  chk_rt_readback: assert property (bus_rd && sel_rt_hi
      |=> bus_rdata == $past(rt_hi))
    else $error("Remote high byte readback wrong.");
  chk_lo_nibble: assert property (bus_rd && (sel_lt_lo || sel_rt_lo)
      |=> bus_rdata[3:0] == 4'h0)
    else $error("Low byte carries bits below the fraction.");

  // The status byte returns the flags as they stood before any clear.
  chk_status_flags: assert property (bus_rd && sel_status
      |=> bus_rdata[6:0] == $past(fi.flags))
    else $error("Status flags readback wrong.");

  // A status read drops a limit flag whose cause is gone.
  chk_status_clear: assert property (bus_rd && sel_status && !lh_trip
      |=> !fi.flags[6])
    else $error("Status read left a flag set after its cause went.");

  // Alarm mode: a set limit or open flag pulls the pin low unless it is masked.
  chk_alert_latch: assert property (fi.mode == sns_pkg::SNS_MODE_ALARM && !fi.mask
      && |fi.flags[6:2] |=> !alert_pin_n)
    else $error("Alarm pin high with a flag set.");
  chk_mask_alert: assert property (fi.mode == sns_pkg::SNS_MODE_ALARM && fi.mask
      |=> alert_pin_n)
    else $error("Masked alarm pin driven low.");

  // Second-output mode ignores low limits and the open flag.
  chk_low_ignored: assert property (fi.mode == sns_pkg::SNS_MODE_SECOND
      && !lh_trip && !rh_trip |=> alert_pin_n)
    else $error("Second output low without a high-limit trip.");

  // The critical pin rises as soon as both channels are clear of hysteresis.
  chk_over_temp_out_n_release: assert property (!l_crit_over && !r_crit_over
      && l_crit_clear && r_crit_clear |=> over_temp_out_n)
    else $error("Over-temp pin stayed low after release.");
endmodule

// ==== testbench/sns_host_model.sv ====
// Purpose: Behavioural two-wire host seen at the byte-command port of the bank.
// Assumes: Each command pulse changes at a falling edge of sys_clk and lasts one cycle.
// Notes:   The serial clock runs only inside a frame and stands low between frames.
`timescale 1ns/1ps
module sns_host_model (
  input  wire logic       sys_clk,
  output logic            bus_ptr_wr,
  output logic            bus_data_wr,
  output logic      [7:0] bus_wdata,
  output logic            bus_rd,
  output logic            bus_ara_rd,
  output logic            scl
);
  // Idle levels from time zero.
  initial begin
    {bus_ptr_wr, bus_data_wr, bus_rd, bus_ara_rd, scl} = 5'h00;
    bus_wdata = 8'hA5;
  end

  // One framed command; the data byte is inverted afterwards so a stale byte never looks valid.
  // address read services alarm
  task automatic send(input logic [1:0] kind, input logic [7:0] val);
    repeat (2) begin
      scl = 1'b1;
      #160;
      scl = 1'b0;
      #160;
    end
    @(negedge sys_clk);
    bus_wdata = val;
    case (kind)
      2'h0: bus_ptr_wr = 1'b1;
      2'h1: bus_data_wr = 1'b1;
      2'h2: bus_rd = 1'b1;
      default: bus_ara_rd = 1'b1;
    endcase
    @(negedge sys_clk);
    {bus_ptr_wr, bus_data_wr, bus_rd, bus_ara_rd} = 4'h0;
    bus_wdata = ~val;
  endtask

  task automatic read(input logic [7:0] ptr);
    send(2'h0, ptr);
    send(2'h2, 8'h00);
  endtask

  // A write command always carries the pointer byte first.
  task automatic write(input logic [7:0] ptr, input logic [7:0] data);
    send(2'h0, ptr);
    send(2'h1, data);
  endtask
endmodule

// ==== testbench/sns_reg_bank_test.sv ====
// Purpose: Self-checking bench of the sensor register bank.
// Assumes: Host commands and converter strobes change at the falling edge.
// Notes:   Read answers are checked against a queue of expected bytes.
`timescale 1ns/1ps
module sns_reg_bank_test;
  logic        sys_clk, rst_n, conv_done, conv_busy, conv_open, scl;
  logic        bus_ptr_wr, bus_data_wr, bus_rd, bus_ara_rd, bus_rvalid;
  logic        shutdown_req, range_ext, alert_pin_n, over_temp_out_n;
  logic [7:0]  bus_wdata, bus_rdata, l_lh, l_ll, l_rh, l_rl, l_lc, l_rc, l_hy, v;
  logic [11:0] c_loc, c_rem, a, b;
  logic [7:0]  exp_q[$];
  logic [7:0]  regs[7]  = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h15, 8'h04};
  logic [11:0] t_loc[5] = '{12'h600, 12'h100, 12'h300, 12'h300, 12'h300};
  logic [11:0] t_rem[5] = '{12'h300, 12'h300, 12'h600, 12'h100, 12'h300};
  int          n_fail, checks, cyc, seed;

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  sns_reg_bank i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_ptr_wr(bus_ptr_wr), .bus_data_wr(bus_data_wr),
    .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_ara_rd(bus_ara_rd), .bus_rdata(bus_rdata),
    .bus_rvalid(bus_rvalid), .conv_done(conv_done), .conv_busy(conv_busy),
    .conv_local(c_loc), .conv_remote(c_rem), .conv_open(conv_open),
    .lim_local_high(l_lh), .lim_local_low(l_ll), .lim_remote_high(l_rh),
    .lim_remote_low(l_rl), .lim_local_crit(l_lc), .lim_remote_crit(l_rc), .lim_hyst(l_hy),
    .shutdown_req(shutdown_req), .range_ext(range_ext), .alert_pin_n(alert_pin_n),
    .over_temp_out_n(over_temp_out_n)
  );

  sns_host_model i_host (
    .sys_clk(sys_clk), .bus_ptr_wr(bus_ptr_wr), .bus_data_wr(bus_data_wr),
    .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_ara_rd(bus_ara_rd), .scl(scl)
  );

  // Each answer takes the oldest note; an answer with no note pending is a fault too.
  always @(negedge sys_clk) begin
    if (bus_rvalid === 1'b1) begin
      checks++;
      if (exp_q.size() == 0 || bus_rdata !== exp_q[0]) begin
        n_fail++;
        $display("MISMATCH t=%0t read got %h", $time, bus_rdata);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  // The whole run needs about 3300 cycles, so this ceiling only cuts a hang short.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("MISMATCH t=%0t timeout", $time);
      results();
    end
  end

  task automatic results();
    if (exp_q.size() != 0) n_fail++;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Notes the expected byte, then reads; two spare cycles let the answer land first.
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.read(p);
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic pin(input logic got, input logic e);
    checks++;
    if (got !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t pin %b want %b", $time, got, e);
    end
  endtask

  // One converter strobe, then time for flags and pins to follow.
  task automatic conv(input logic [11:0] lo, input logic [11:0] re, input logic op);
    @(negedge sys_clk);
    c_loc = lo;
    c_rem = re;
    conv_open = op;
    conv_done = 1'b1;
    @(negedge sys_clk);
    conv_done = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic ara();
    i_host.send(2'h3, 8'h00);
    repeat (2) @(negedge sys_clk);
  endtask

  initial begin
    seed = 32'h7abd;
    {rst_n, conv_done, conv_busy, conv_open, c_loc, c_rem} = '0;
    {l_lh, l_ll, l_rh, l_rl, l_lc, l_rc, l_hy} = {8'h50, 8'h00, 8'h50, 8'h00, 8'h7F, 8'h7F, 8'h0A};
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    foreach (regs[i]) rd(regs[i], 8'h00);
    $display("test reset values done");
    v = 8'($random(seed));
    i_host.write(8'h09, v);
    rd(8'h03, v & 8'hE4);
    pin(shutdown_req, v[6]);
    pin(range_ext, v[2]);
    i_host.write(8'h03, ~v);
    rd(8'h03, v & 8'hE4);
    i_host.write(8'h09, 8'h00);
    $display("test setup done");
    {l_lh, l_rh, l_ll, l_rl} = {8'h7F, 8'h7F, 8'h00, 8'h00};
    repeat (4) begin
      a = 12'($random(seed)) & 12'h7FF;
      b = 12'($random(seed)) & 12'h7FF;
      conv(a, b, 1'b0);
      rd(8'h00, a[11:4]);
      rd(8'h15, {a[3:0], 4'h0});
      rd(8'h01, b[11:4]);
      rd(8'h10, {b[3:0], 4'h0});
    end
    $display("test split results done");
    conv(12'h123, 12'h456, 1'b0);
    rd(8'h00, 8'h12);
    conv(12'h789, 12'h456, 1'b0);
    rd(8'h15, 8'h30);
    rd(8'h00, 8'h78);
    rd(8'h10, 8'h60);
    conv(12'h789, 12'h3BC, 1'b0);
    rd(8'h01, 8'h45);
    rd(8'h10, 8'hC0);
    rd(8'h02, 8'h00);
    conv(12'h789, 12'h5EF, 1'b0);
    rd(8'h10, 8'hF0);
    rd(8'h01, 8'h5E);
    i_host.write(8'h01, 8'hFF);
    rd(8'h01, 8'h5E);
    conv_busy = 1'b1;
    rd(8'h02, 8'h80);
    conv_busy = 1'b0;
    $display("test freeze and busy done");
    conv(12'h300, 12'h300, 1'b0);
    {l_lh, l_ll, l_rh, l_rl} = {8'h50, 8'h20, 8'h50, 8'h20};
    for (int k = 0; k < 5; k++) begin
      conv(t_loc[k], t_rem[k], k == 4);
      pin(alert_pin_n, 1'b0);
      rd(8'h02, 8'(8'h40 >> k));
      rd(8'h02, 8'(8'h40 >> k));
      conv(12'h300, 12'h300, 1'b0);
      ara();
      pin(alert_pin_n, 1'b0);
      rd(8'h02, 8'(8'h40 >> k));
      rd(8'h02, 8'h00);
      pin(alert_pin_n, 1'b0);
      ara();
      pin(alert_pin_n, 1'b1);
    end
    $display("test alarm latch done");
    i_host.write(8'h09, 8'h80);
    conv(12'h600, 12'h300, 1'b0);
    pin(alert_pin_n, 1'b1);
    conv(12'h300, 12'h300, 1'b0);
    rd(8'h02, 8'h40);
    rd(8'h02, 8'h00);
    ara();
    i_host.write(8'h09, 8'hA0);
    conv(12'h600, 12'h300, 1'b0);
    pin(alert_pin_n, 1'b0);
    rd(8'h02, 8'h40);
    conv(12'h300, 12'h300, 1'b0);
    pin(alert_pin_n, 1'b1);
    rd(8'h02, 8'h00);
    conv(12'h100, 12'h300, 1'b1);
    pin(alert_pin_n, 1'b1);
    rd(8'h02, 8'h24);
    conv(12'h300, 12'h300, 1'b0);
    rd(8'h02, 8'h04);
    rd(8'h02, 8'h00);
    ara();
    i_host.write(8'h09, 8'h00);
    $display("test mask and second output done");
    {l_lh, l_rh, l_lc, l_rc} = {8'hFF, 8'hFF, 8'h40, 8'h40};
    for (int k = 0; k < 2; k++) begin
      conv(k ? 12'h300 : 12'h500, k ? 12'h500 : 12'h300, 1'b0);
      pin(over_temp_out_n, 1'b0);
      rd(8'h02, 8'(8'h01 << k));
      conv(k ? 12'h300 : 12'h3A0, k ? 12'h3A0 : 12'h300, 1'b0);
      pin(over_temp_out_n, 1'b0);
      rd(8'h02, 8'(8'h01 << k));
      conv(k ? 12'h300 : 12'h360, k ? 12'h360 : 12'h300, 1'b0);
      pin(over_temp_out_n, 1'b1);
      rd(8'h02, 8'h00);
    end
    $display("test critical limits done");
    rst_n = 1'b0;
    @(negedge sys_clk);
    rst_n = 1'b1;
    conv(12'h3A5, 12'h000, 1'b0);
    exp_q.push_back(8'h3A);
    i_host.send(2'h2, 8'h00);
    repeat (3) @(negedge sys_clk);
    $display("test pointer reset done");
    results();
  end
endmodule
